// File: rtl/osd_cmd_pkg.sv
/*
  Constants and carrier types for the on-screen-display serial command decoder.
  Assumes a 32-bit classic Wishbone register bus and a single system clock.
*/
package osd_cmd_pkg;

  localparam int ROWS = 12;
  localparam int COLS = 24;
  localparam int CELLS = ROWS * COLS;
  localparam int CELL_W = 9;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_VRAM_ADDR = 8'h08;
  localparam logic [7:0] OFS_VRAM_DATA = 8'h0c;
  localparam logic [7:0] OFS_DISP_A = 8'h10;
  localparam logic [7:0] OFS_DISP_B = 8'h14;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Command prefixes
  localparam logic [3:0] P1_DISPLAY = 4'h1;
  localparam logic [3:0] P1_COLOUR = 4'h2;
  localparam logic [3:0] P1_BACKGROUND = 4'h3;
  localparam logic [4:0] P1_MODE = 5'h08;
  localparam logic [4:0] P1_STANDARD = 5'h09;
  localparam logic [3:0] P1_OSC = 4'h5;
  localparam logic [5:0] P2_POSITION = 6'h20;
  localparam logic [6:0] P2_WRITE_ADDR = 7'h44;
  localparam logic [6:0] P2_LEVEL = 7'h48;
  localparam logic [6:0] P2_CHAR_SIZE = 7'h4c;
  localparam logic [6:0] P2_TEST = 7'h58;
  localparam logic [5:0] P2_CHARACTER = 6'h30;

  typedef struct packed {
    logic disp_on;
    logic line_control_bit;
    logic blink_sel_hi;
    logic blink_sel_lo;
    logic [2:0] video_rgb;
    logic background_sel_hi;
    logic background_sel_lo;
    logic ext_mode;
    logic xtal_on;
    logic [2:0] video_standard_sel;
    logic osc_method;
    logic pedestal_level_sel;
    logic amplitude_sel_hi;
    logic amplitude_sel_lo;
    logic [4:0] vertical_start_field;
    logic [4:0] horizontal_start_field;
    logic [ROWS-1:0] char_size_bit;
  } osd_state_s;

  typedef struct packed {
    logic [3:0] write_row_field;
    logic [4:0] write_column_field;
  } wr_addr_s;

endpackage

// File: rtl/osd_serial_command_decoder.sv
/*
  Serial command decoder: assembles bytes from the host's serial pins, executes
  single-byte, two-byte and contiguous character commands, holds the display
  state and the character RAM, and offers a Wishbone register view.
  Assumes serial pins are asynchronous to clk_sys and far slower than it.
*/
`timescale 1ns/1ps

module osd_serial_command_decoder
  import osd_cmd_pkg::*;
(
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic ser_clk, // Serial shift clock from host
  input wire logic ser_data, // Serial command data from host
  input wire logic ser_cs_n, // Serial frame select, active low
  input wire logic bit_order_select_pin, // High selects LSB-first order
  input wire logic [3:0] rd_row, // Display-side read row
  input wire logic [4:0] rd_col, // Display-side read column
  output logic [CELL_W-1:0] rd_cell, // Blink bit and code at rd_row/rd_col
  output osd_state_s disp_state, // Display state
  output wr_addr_s wr_addr, // Current character write address
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o // Wishbone acknowledge
);

  function automatic logic [8:0] cell_index(input logic [3:0] r, input logic [4:0] c);
    cell_index = 9'(r * COLS + c);
  endfunction

  function automatic logic in_area(input logic [3:0] r, input logic [4:0] c);
    in_area = (r < 4'(ROWS)) && (c < 5'(COLS));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] clk_meta, dat_meta, cs_meta, ord_meta;
  logic sclk_prev;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      {clk_meta, dat_meta, ord_meta, sclk_prev} <= 7'h00;
      cs_meta <= 2'h3;
    end
    else
    begin
      clk_meta <= {clk_meta[0], ser_clk};
      dat_meta <= {dat_meta[0], ser_data};
      cs_meta <= {cs_meta[0], ser_cs_n};
      ord_meta <= {ord_meta[0], bit_order_select_pin};
      sclk_prev <= clk_meta[1];
    end
  end

  logic frame_on;
  logic sclk_rise;
  assign frame_on = !cs_meta[1];
  assign sclk_rise = clk_meta[1] && !sclk_prev && frame_on;

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic [7:0] byte_val;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      shreg <= 8'h00;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      byte_val <= 8'h00;
    end
    else
    begin
      byte_done <= 1'b0;
      if (!frame_on)
        bit_cnt <= 3'h0;
      else if (sclk_rise)
      begin
        bit_cnt <= bit_cnt + 3'h1;
        if (ord_meta[1])
          shreg <= {dat_meta[1], shreg[7:1]};
        else
          shreg <= {shreg[6:0], dat_meta[1]};
        if (bit_cnt == 3'h7)
        begin
          byte_done <= 1'b1;
          byte_val <= ord_meta[1] ? {dat_meta[1], shreg[7:1]} : {shreg[6:0], dat_meta[1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing
  typedef enum logic [2:0] {
    ST_FIRST = 3'b001,
    ST_SECOND = 3'b010,
    ST_CONTIG = 3'b100
  } seq_e;

  seq_e seq;
  logic [7:0] first_byte;
  logic contig_blink;
  logic [31:0] ctrl;
  logic enable;
  logic exec1, exec2, exec_char;
  logic [15:0] cmd;
  assign enable = ctrl[CTRL_ENABLE_BIT];
  assign cmd = {first_byte, byte_val};
  assign exec1 = byte_done && enable && seq == ST_FIRST && !byte_val[7];
  assign exec2 = byte_done && enable && seq == ST_SECOND;
  assign exec_char = byte_done && enable && seq == ST_CONTIG;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      seq <= ST_FIRST;
      first_byte <= 8'h00;
      contig_blink <= 1'b0;
    end
    else if (!frame_on)
      seq <= ST_FIRST;
    else if (byte_done && enable)
    begin
      unique case (seq)
        ST_FIRST:
        begin
          first_byte <= byte_val;
          if (byte_val[7])
            seq <= ST_SECOND;
        end
        ST_SECOND:
        begin
          if (first_byte[7:2] == P2_CHARACTER)
          begin
            seq <= ST_CONTIG;
            contig_blink <= first_byte[1];
          end
          else
            seq <= ST_FIRST;
        end
        ST_CONTIG:
          seq <= ST_CONTIG;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display state
  logic [7:0] cmd_count;
  logic test_seen;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      disp_state <= '0;
      cmd_count <= 8'h00;
      test_seen <= 1'b0;
    end
    else
    begin
      if (exec1)
      begin
        cmd_count <= cmd_count + 8'h01;
        if (byte_val[7:4] == P1_DISPLAY)
          {disp_state.disp_on, disp_state.line_control_bit, disp_state.blink_sel_hi,
           disp_state.blink_sel_lo} <= byte_val[3:0];
        if (byte_val[7:4] == P1_COLOUR && !byte_val[0])
          disp_state.video_rgb <= byte_val[3:1];
        if (byte_val[7:4] == P1_BACKGROUND && !byte_val[3] && !byte_val[0])
          {disp_state.background_sel_hi, disp_state.background_sel_lo} <= byte_val[2:1];
        if (byte_val[7:3] == P1_MODE && !byte_val[1])
        begin
          disp_state.ext_mode <= byte_val[2];
          disp_state.xtal_on <= byte_val[0];
        end
        if (byte_val[7:3] == P1_STANDARD)
          disp_state.video_standard_sel <= byte_val[2:0];
        if (byte_val[7:4] == P1_OSC && byte_val[3:2] == 2'h0 && !byte_val[0])
          disp_state.osc_method <= byte_val[1];
      end
      if (exec2)
      begin
        cmd_count <= cmd_count + 8'h01;
        if (cmd[15:10] == P2_POSITION)
        begin
          disp_state.vertical_start_field <= cmd[9:5];
          disp_state.horizontal_start_field <= cmd[4:0];
        end
        if (cmd[15:9] == P2_LEVEL && cmd[7:3] == 5'h00 && cmd[2])
        begin
          disp_state.pedestal_level_sel <= cmd[8];
          {disp_state.amplitude_sel_hi, disp_state.amplitude_sel_lo} <= cmd[1:0];
        end
        if (cmd[15:9] == P2_CHAR_SIZE && cmd[8:7] == 2'h0 && cmd[5:4] == 2'h0 && cmd[3:0] < 4'(ROWS))
          disp_state.char_size_bit[cmd[3:0]] <= cmd[6];
        if (cmd[15:9] == P2_TEST)
          test_seen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write address and character RAM
  logic [CELL_W-1:0] vram [CELLS];
  logic char_wr;
  logic [CELL_W-1:0] char_val;
  assign char_wr = (exec2 && cmd[15:10] == P2_CHARACTER) || exec_char;
  assign char_val = exec_char ? {contig_blink, byte_val} : {cmd[9], cmd[7:0]};

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      wr_addr <= '0;
    else if (exec2 && cmd[15:9] == P2_WRITE_ADDR)
      wr_addr <= '{write_row_field: cmd[8:5], write_column_field: cmd[4:0]};
    else if (char_wr && in_area(wr_addr.write_row_field, wr_addr.write_column_field))
    begin
      if (wr_addr.write_column_field == 5'(COLS - 1))
      begin
        wr_addr.write_column_field <= 5'h00;
        wr_addr.write_row_field <= (wr_addr.write_row_field == 4'(ROWS - 1)) ? 4'h0
                                   : wr_addr.write_row_field + 4'h1;
      end
      else
        wr_addr.write_column_field <= wr_addr.write_column_field + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      for (int i = 0; i < CELLS; i++)
        vram[i] <= '0;
    else if (exec1 && byte_val == 8'h00)
      for (int i = 0; i < CELLS; i++)
        vram[i] <= '0;
    else if (char_wr && in_area(wr_addr.write_row_field, wr_addr.write_column_field))
      vram[cell_index(wr_addr.write_row_field, wr_addr.write_column_field)] <= char_val;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rd_cell <= '0;
    else if (in_area(rd_row, rd_col))
      rd_cell <= vram[cell_index(rd_row, rd_col)];
    else
      rd_cell <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic [8:0] sw_rd_addr;
  logic bus_req;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl <= CTRL_RESET;
      sw_rd_addr <= 9'h000;
    end
    else if (bus_req && wb_we_i)
    begin
      if (wb_adr_i == OFS_CTRL && wb_sel_i[0])
        ctrl[0] <= wb_dat_i[0];
      if (wb_adr_i == OFS_VRAM_ADDR)
      begin
        if (wb_sel_i[0])
          sw_rd_addr[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          sw_rd_addr[8] <= wb_dat_i[8];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0;
      if (bus_req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          OFS_CTRL: wb_dat_o <= {31'h0, ctrl[0]};
          OFS_STATUS: wb_dat_o <= {11'h0, wr_addr, test_seen, seq, cmd_count};
          OFS_VRAM_ADDR: wb_dat_o <= {23'h0, sw_rd_addr};
          OFS_VRAM_DATA: wb_dat_o <= (sw_rd_addr < 9'(CELLS)) ? {23'h0, vram[sw_rd_addr]} : 32'h0;
          OFS_DISP_A: wb_dat_o <= {4'h0, disp_state[$bits(osd_state_s)-1:ROWS]};
          OFS_DISP_B: wb_dat_o <= {20'h0, disp_state.char_size_bit};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule

// File: test/osd_cmd_checker.sv
/*
  Port-level assertions for the serial command decoder.
  Bound to the decoder top module; sees only its ports.
*/
`timescale 1ns/1ps
module osd_cmd_checker
  import osd_cmd_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic ser_clk, // Serial clock
  input wire logic ser_cs_n, // Frame select
  input wire logic [3:0] rd_row, // Read row
  input wire logic [4:0] rd_col, // Read column
  input wire logic [CELL_W-1:0] rd_cell, // Read cell
  input osd_state_s disp_state, // Display state
  input wr_addr_s wr_addr, // Write address
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Bus address
  input wire logic [31:0] wb_dat_o, // Bus read data
  input wire logic wb_ack_o // Bus acknowledge
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ser_idle_s;
    $stable(ser_clk) [*8] ##1 $stable(ser_clk) [*8];
  endsequence
  sequence cs_idle_s;
    ser_cs_n [*8] ##1 ser_cs_n [*8];
  endsequence
  a_ack_take: assert property (take_s |=> wb_ack_o) else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data without ack");
  a_unmapped_zero: assert property (take_s ##0 (!wb_we_i && wb_adr_i >= 8'h18) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_cell_outside: assert property ((rd_row >= 4'hc || rd_col >= 5'h18) |=> rd_cell == '0)
    else $error("cell outside area not zero");
  a_state_idle: assert property (ser_idle_s |=> $stable(disp_state))
    else $error("state changed without serial traffic");
  a_waddr_idle: assert property (cs_idle_s |=> $stable(wr_addr))
    else $error("write address changed outside frame");
endmodule
bind osd_serial_command_decoder osd_cmd_checker i_chk (.clk_sys, .nrst, .ser_clk, .ser_cs_n, .rd_row, .rd_col,
  .rd_cell, .disp_state, .wr_addr, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o);

// File: test/osd_host_model.sv
/*
  Host side of the serial command link: sends byte frames.
  Paced by clk_sys; each serial clock phase lasts four system clocks.
*/
`timescale 1ns/1ps
module osd_host_model (
  input wire logic clk_sys, // Pacing clock
  output logic ser_clk, // Serial clock, still outside frames
  output logic ser_data, // Serial data
  output logic ser_cs_n // Frame select, active low
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_cs_n = 1'b1;
  end
  task automatic send(input logic [7:0] q[$], input logic lsb);
    @(posedge clk_sys);
    ser_cs_n <= 1'b0;
    foreach (q[j])
      for (int i = 0; i < 8; i++)
      begin
        ser_data <= lsb ? q[j][i] : q[j][7 - i];
        repeat (4) @(posedge clk_sys);
        ser_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ser_clk <= 1'b0;
      end
    repeat (4) @(posedge clk_sys);
    ser_cs_n <= 1'b1;
    ser_data <= ~ser_data; // Released line holds no value
  endtask
endmodule

// File: test/tb.sv
/*
  Self-checking bench for the serial command decoder.
  Host model drives the serial pins; tasks speak classic Wishbone.
*/
`timescale 1ns/1ps
module tb;
  import osd_cmd_pkg::*;
  logic clk_sys = 0, nrst = 0, order = 0, cyc = 0, stb = 0, we = 0, ack, ser_clk, ser_data, ser_cs_n;
  logic [3:0] rd_row = 0;
  logic [4:0] rd_col = 0;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, dat_o;
  logic [CELL_W-1:0] rd_cell;
  osd_state_s disp_state, exp;
  wr_addr_s wr_addr;
  int fails = 0, comparisons = 0;
  always #20 clk_sys = ~clk_sys;
  osd_host_model i_host (.clk_sys(clk_sys), .ser_clk(ser_clk), .ser_data(ser_data), .ser_cs_n(ser_cs_n));
  osd_serial_command_decoder i_dut (.clk_sys(clk_sys), .nrst(nrst), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_cs_n(ser_cs_n), .bit_order_select_pin(order), .rd_row(rd_row), .rd_col(rd_col), .rd_cell(rd_cell),
    .disp_state(disp_state), .wr_addr(wr_addr), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    int i = 0;
    @(posedge clk_sys);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk_sys); while (ack !== 1'b1 && ++i < 50);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (i == 50)
    begin
      fails++;
      end_sim();
    end
  endtask
  task automatic frame(logic [7:0] q[$]);
    @(posedge clk_sys);
    i_host.send(q, order);
    repeat (16) @(posedge clk_sys);
  endtask
  task automatic look(logic [3:0] r, logic [4:0] c, logic [8:0] e);
    rd_row <= r;
    rd_col <= c;
    repeat (2) @(posedge clk_sys);
    chk("cell", rd_cell, e);
  endtask
  function automatic osd_state_s apply(osd_state_s s, logic [15:0] c);
    if (c[15:12] == P1_DISPLAY) {s.disp_on, s.line_control_bit, s.blink_sel_hi, s.blink_sel_lo} = c[11:8];
    if (c[15:12] == P1_COLOUR && !c[8]) s.video_rgb = c[11:9];
    if (c[15:12] == P1_BACKGROUND && !c[11] && !c[8]) {s.background_sel_hi, s.background_sel_lo} = c[10:9];
    if (c[15:11] == P1_MODE && !c[9]) {s.ext_mode, s.xtal_on} = {c[10], c[8]};
    if (c[15:11] == P1_STANDARD) s.video_standard_sel = c[10:8];
    if (c[15:12] == P1_OSC && c[11:10] == 0 && !c[8]) s.osc_method = c[9];
    if (c[15:10] == P2_POSITION) {s.vertical_start_field, s.horizontal_start_field} = c[9:0];
    if (c[15:9] == P2_LEVEL && c[7:3] == 0 && c[2]) {s.pedestal_level_sel, s.amplitude_sel_hi, s.amplitude_sel_lo} = {c[8], c[1:0]};
    if (c[15:9] == P2_CHAR_SIZE && c[8:7] == 0 && c[5:4] == 0) s.char_size_bit[c[3:0]] = c[6];
    return s;
  endfunction
  initial
  begin
    logic [31:0] q;
    logic [15:0] c;
    static logic [15:0] p[10] = '{16'h1, 16'h2, 16'h3, 16'h8, 16'h9, 16'h5, 16'h20, 16'h48, 16'h4c, 16'h58};
    static int w[10] = '{4, 4, 4, 5, 5, 4, 6, 7, 7, 7};
    void'($urandom(32'hbcae));
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    exp = '0;
    chk("state", disp_state, exp);
    wb(1'b0, OFS_CTRL, 32'h0, q);
    chk("ctrl", q, CTRL_RESET);
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 60; k++)
    begin
      c = (16'($urandom()) >> w[k % 10]) | (p[k % 10] << (16 - w[k % 10]));
      if (c[15:9] == P2_CHAR_SIZE) c[3:0] = c[3:0] % 4'hc;
      order <= k[0];
      if (c[15]) frame('{c[15:8], c[7:0]}); else frame('{c[15:8]});
      exp = apply(exp, c);
      chk("state", disp_state, exp);
    end
    wb(1'b0, OFS_DISP_A, 32'h0, q);
    chk("disp_a", q, {4'h0, exp[$bits(osd_state_s)-1:ROWS]});
    wb(1'b0, OFS_DISP_B, 32'h0, q);
    chk("disp_b", q, {20'h0, exp.char_size_bit});
    $display("test commands done");
    order <= 1'b0;
    frame('{8'h88 | 8'h0, 8'h76});
    frame('{8'hc2, 8'ha5, 8'h3c, 8'h7e});
    chk("waddr", wr_addr, {4'h4, 5'h01});
    look(4'h3, 5'h16, 9'h1a5);
    look(4'h3, 5'h17, 9'h13c);
    look(4'h4, 5'h00, 9'h17e);
    look(4'hc, 5'h00, 9'h000);
    wb(1'b1, OFS_VRAM_ADDR, 32'h5f, q);
    wb(1'b0, OFS_VRAM_DATA, 32'h0, q);
    chk("vram", q, 32'h13c);
    frame('{8'h00});
    look(4'h3, 5'h16, 9'h000);
    $display("test characters done");
    wb(1'b1, OFS_CTRL, 32'h0, q);
    frame('{8'h1f});
    chk("disabled", disp_state, exp);
    wb(1'b1, OFS_CTRL, 32'h1, q);
    $display("test enable done");
    end_sim();
  end
endmodule
